// ### rtl/tdsl_calc_if.sv
// carrier between the lookup logic and one set point adder
// assumes one instance per output channel
`timescale 1ns/1ps
interface tdsl_calc_if;
    tdsl_pkg::tdsl_byte_t fine;
    tdsl_pkg::tdsl_byte_t coarse;
    tdsl_pkg::tdsl_code_t code;
    modport lookup (output fine, output coarse, input code);
    modport adder (input fine, input coarse, output code);
endinterface

// ### rtl/tdsl_consts.svh
// timing-free constants of the temperature indexed set point block
// assumes inclusion by bare name from the setpoint and top modules
`ifndef TDSL_CONSTS_SVH
`define TDSL_CONSTS_SVH
`define TDSL_PAGE_CH0 8'h04
`define TDSL_PAGE_CH3 8'h07
`define TDSL_FINE_FIRST 8'h80
`define TDSL_FINE_LAST 8'hAF
`define TDSL_OFF_FIRST 8'hF8
`define TDSL_IDX_RESET 8'h80
`define TDSL_TBL_RESET 8'h00
`define TDSL_FINE_ENTRIES 48
`define TDSL_OFF_ENTRIES 8
`define TDSL_T_LOW (-40)
`define TDSL_T_KNEE 56
`define TDSL_T_CLAMP 102
`define TDSL_T_KNEE_BIAS 8
`define TDSL_FINE_KNEE_IDX 24
`define TDSL_OFF_KNEE_IDX 8
`define TDSL_OFF_WARM_BASE 5
`define TDSL_CODE_MAX 10'h3FF
`endif

// ### rtl/tdsl_pkg.sv
// shared types of the temperature indexed set point block
// assumes nothing of its surroundings
package tdsl_pkg;
    typedef logic [7:0] tdsl_byte_t;
    typedef logic [9:0] tdsl_code_t;
    typedef logic [5:0] tdsl_fidx_t;
    typedef logic [2:0] tdsl_oidx_t;
endpackage

// ### rtl/tdsl_setpoint.sv
// set point adder: fine byte plus four times coarse byte
// assumes table bytes arrive already selected by the index pointer
`timescale 1ns/1ps
`include "tdsl_consts.svh"
module tdsl_setpoint (
    tdsl_calc_if.adder calc
);
    logic [10:0] sum;
    // widest sum is 255 + 1020, so one extra bit catches the overflow
    assign sum = {3'h0, calc.fine} + {1'h0, calc.coarse, 2'h0};
    // saturate rather than wrap so a hot profile never flips to zero
    assign calc.code = sum[10] ? `TDSL_CODE_MAX : sum[9:0];
endmodule

// ### rtl/tdsl_top.sv
// temperature indexed set point lookup for four output channels
// assumes temperature, table port and index port are same-clock logic
//
// Notes on behaviour
// - each channel set point is fine byte plus four times coarse byte
// - four fine tables on pages 04h-07h, bytes 80h-AFh, one per channel
// - all fine tables share one unsigned byte layout and one adder path
// - fine entries step 4 degrees from -40 up to 56
// - fine entries step 2 degrees from 56, last entry at 102 and above
// - first fine entry serves the lowest band, including below -40
// - four coarse tables at bytes F8h-FFh on pages 04h-07h
// - all coarse tables share one byte layout
// - coarse entries step 16 degrees from -8 to 88, last at 88 and above
// - below -8 degrees the first coarse entry F8h is used
// - F9h covers -8 to +8, later addresses cover the next bands
// - coarse address derives from the single fine index pointer
// - falling temperature gets one degree added before indexing
// - table mode channels reload their code after every conversion
// - with auto index off host writes pointer except in a conv_done cycle, automatic updates blocked
`timescale 1ns/1ps
`include "tdsl_consts.svh"
module tdsl_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] temp_value,
    input wire logic conv_done,
    input wire logic auto_index_enable,
    input wire logic [3:0] table_mode,
    input wire logic idx_wr,
    input wire logic [7:0] idx_wdata,
    input wire logic tbl_wr,
    input wire logic tbl_rd,
    input wire logic [7:0] tbl_page,
    input wire logic [7:0] tbl_addr,
    input wire logic [7:0] tbl_wdata,
    input wire logic code_wr,
    input wire logic [1:0] code_sel,
    input wire logic [9:0] code_wdata,
    output logic [7:0] tbl_rdata,
    output logic [7:0] temperature_index_pointer,
    output logic [9:0] output_channel_0,
    output logic [9:0] output_channel_1,
    output logic [9:0] output_channel_2,
    output logic [9:0] output_channel_3
);
    // nonvolatile tables modelled as plain arrays, content undefined until written
    tdsl_pkg::tdsl_byte_t fine_setpoint_table [4][`TDSL_FINE_ENTRIES];
    tdsl_pkg::tdsl_byte_t coarse_offset_table [4][`TDSL_OFF_ENTRIES];
    // per channel codes, pointer and read-back state
    tdsl_pkg::tdsl_code_t code_r [4];
    logic [7:0] index_r;
    logic signed [7:0] prev_temp_r;
    logic load_pend_r;
    logic [7:0] rdata_r;
    tdsl_pkg::tdsl_fidx_t fine_sel;
    tdsl_pkg::tdsl_oidx_t off_sel;
    logic signed [7:0] temp_int;
    logic [1:0] page_ch;
    logic page_hit;
    logic fine_hit;
    logic off_hit;

    // whole degrees, floor of the left-justified reading
    assign temp_int = temp_value[15:8];

    // pointer from temperature, with hysteresis on falling readings
    // 4 degree bands up to the knee, 2 degree bands above it
    // both ends clamp, so any reading maps to a valid entry
    function automatic logic [7:0] calc_index(input logic signed [7:0] t,
                                              input logic falling);
        logic signed [9:0] th;
        logic signed [9:0] rel;
        th = {{2{t[7]}}, t} + (falling ? 10'sh001 : 10'sh000);
        rel = 10'sh000;
        if (th < 10'(`TDSL_T_LOW)) begin
            rel = 10'sh000;
        end else if (th < 10'(`TDSL_T_KNEE)) begin
            rel = (th - 10'(`TDSL_T_LOW)) >>> 2;
        end else if (th >= 10'(`TDSL_T_CLAMP)) begin
            rel = 10'(`TDSL_FINE_ENTRIES - 1);
        end else begin
            rel = (th - 10'(`TDSL_T_KNEE_BIAS)) >>> 1;
        end
        calc_index = `TDSL_FINE_FIRST + rel[7:0];
    endfunction

    // coarse entry from the fine entry number, one pointer for both
    // a 16 degree band spans four fine entries below the knee, eight above
    function automatic tdsl_pkg::tdsl_oidx_t calc_offset(input tdsl_pkg::tdsl_fidx_t f);
        logic [5:0] o;
        o = 6'h00;
        if (f < 6'(`TDSL_OFF_KNEE_IDX)) begin
            o = 6'h00;
        end else if (f < 6'(`TDSL_FINE_KNEE_IDX)) begin
            o = ((f - 6'(`TDSL_OFF_KNEE_IDX)) >> 2) + 6'h01;
        end else begin
            o = ((f - 6'(`TDSL_FINE_KNEE_IDX)) >> 3) + 6'(`TDSL_OFF_WARM_BASE);
        end
        if (o > 6'(`TDSL_OFF_ENTRIES - 1)) begin
            o = 6'(`TDSL_OFF_ENTRIES - 1);
        end
        calc_offset = o[2:0];
    endfunction

    // byte offset inside the fine area; callers check the range first
    function automatic tdsl_pkg::tdsl_fidx_t fine_slot(input logic [7:0] a);
        fine_slot = 6'(a - `TDSL_FINE_FIRST);
    endfunction

    // byte offset inside the coarse area; callers check the range first
    function automatic tdsl_pkg::tdsl_oidx_t off_slot(input logic [7:0] a);
        off_slot = 3'(a - `TDSL_OFF_FIRST);
    endfunction

    // pointer bit 7 is ignored; entries past the table clamp to the last
    always_comb begin
        fine_sel = (index_r[6:0] > 7'(`TDSL_FINE_ENTRIES - 1)) ?
                   6'(`TDSL_FINE_ENTRIES - 1) : index_r[5:0];
    end
    assign off_sel = calc_offset(fine_sel);

    // host table port decode, pages 04h-07h only
    assign page_hit = (tbl_page >= `TDSL_PAGE_CH0) && (tbl_page <= `TDSL_PAGE_CH3);
    assign page_ch = 2'(tbl_page - `TDSL_PAGE_CH0);
    assign fine_hit = page_hit && (tbl_addr >= `TDSL_FINE_FIRST) &&
                      (tbl_addr <= `TDSL_FINE_LAST);
    assign off_hit = page_hit && (tbl_addr >= `TDSL_OFF_FIRST);

    // fine table writes; no reset, like the nonvolatile store
    always_ff @(posedge clk_sys) begin
        if (tbl_wr && fine_hit) begin
            fine_setpoint_table[page_ch][fine_slot(tbl_addr)] <= tbl_wdata;
        end
    end

    // coarse table writes, same page decode as the fine table
    always_ff @(posedge clk_sys) begin
        if (tbl_wr && off_hit) begin
            coarse_offset_table[page_ch][off_slot(tbl_addr)] <= tbl_wdata;
        end
    end

    // read data, one cycle after the strobe; unmapped bytes read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (tbl_rd) begin
            if (fine_hit) begin
                rdata_r <= fine_setpoint_table[page_ch][fine_slot(tbl_addr)];
            end else if (off_hit) begin
                rdata_r <= coarse_offset_table[page_ch][off_slot(tbl_addr)];
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    // index pointer: automatic after a conversion, else host written
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            index_r <= `TDSL_IDX_RESET;
        end else if (conv_done) begin
            if (auto_index_enable) begin
                index_r <= calc_index(temp_int, temp_int < prev_temp_r);
            end
        end else if (idx_wr && !auto_index_enable) begin
            index_r <= idx_wdata;
        end
    end

    // last converted reading, kept whatever the pointer mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_temp_r <= 8'sh00;
        end else if (conv_done) begin
            prev_temp_r <= temp_int;
        end
    end

    // reload waits one cycle so the new pointer has settled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            load_pend_r <= 1'b0;
        end else begin
            load_pend_r <= conv_done;
        end
    end

    // one adder per channel; identical byte layout means one path
    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_ch
            // one carrier per channel keeps the adder free of channel numbers
            tdsl_calc_if calc ();
            assign calc.fine = fine_setpoint_table[ch][fine_sel];
            assign calc.coarse = coarse_offset_table[ch][off_sel];
            tdsl_setpoint u_sp (
                .calc(calc)
            );
            // table mode reloads, otherwise the host may write the code
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    code_r[ch] <= 10'h000;
                end else if (table_mode[ch]) begin
                    if (load_pend_r) begin
                        code_r[ch] <= calc.code;
                    end
                end else if (code_wr && (code_sel == 2'(ch))) begin
                    code_r[ch] <= code_wdata;
                end
            end
        end
    endgenerate

    // every output comes straight from a register
    assign tbl_rdata = rdata_r;
    assign temperature_index_pointer = index_r;
    assign output_channel_0 = code_r[0];
    assign output_channel_1 = code_r[1];
    assign output_channel_2 = code_r[2];
    assign output_channel_3 = code_r[3];
endmodule

// ### testbench/tdsl_host.sv
// host model that programs and reads table bytes
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module tdsl_host (
    input wire logic clk_sys,
    input wire logic [7:0] tbl_rdata,
    output logic tbl_wr = 1'b0,
    output logic tbl_rd = 1'b0,
    output logic [7:0] tbl_page = 8'h00,
    output logic [7:0] tbl_addr = 8'h00,
    output logic [7:0] tbl_wdata = 8'h00
);
    // released data flips so stale bytes never pass as valid
    task automatic put(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_sys);
        {tbl_wr, tbl_page, tbl_addr, tbl_wdata} <= {1'b1, pg, ad, d};
        @(negedge clk_sys);
        tbl_wr <= 1'b0;
        tbl_wdata <= ~d;
    endtask
    task automatic get(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
        @(negedge clk_sys);
        {tbl_rd, tbl_page, tbl_addr} <= {1'b1, pg, ad};
        @(negedge clk_sys);
        tbl_rd <= 1'b0;
        d = tbl_rdata;
    endtask
    // tables hold nothing useful until written
    task automatic program_all;
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 48; n++) put(8'(4 + c), 8'(128 + n), 8'(c * 64 + n));
            for (int k = 0; k < 8; k++) put(8'(4 + c), 8'(248 + k), 8'(c * 80 + k));
        end
    endtask
endmodule

// ### testbench/tdsl_props.sv
// port checker of the set point block
// assumes a bind onto tdsl_top and one clock domain
`timescale 1ns/1ps
module tdsl_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] temp_value,
    input wire logic conv_done,
    input wire logic auto_index_enable,
    input wire logic [3:0] table_mode,
    input wire logic idx_wr,
    input wire logic [7:0] idx_wdata,
    input wire logic code_wr,
    input wire logic [1:0] code_sel,
    input wire logic [9:0] code_wdata,
    input wire logic tbl_rd,
    input wire logic [7:0] tbl_page,
    input wire logic [7:0] tbl_rdata,
    input wire logic [7:0] temperature_index_pointer,
    input wire logic [9:0] output_channel_0
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // automatic conversions at either end of the range
    sequence hot_s;
        conv_done && auto_index_enable && $signed(temp_value[15:8]) >= 102;
    endsequence
    sequence cold_s;
        conv_done && auto_index_enable && $signed(temp_value[15:8]) < -37;
    endsequence
    hot_clamp_a: assert property (hot_s |=> temperature_index_pointer == 8'hAF)
        else $error("hot pointer not clamped");
    cold_floor_a: assert property (cold_s |=> temperature_index_pointer == 8'h80)
        else $error("cold pointer not first entry");
    ptr_range_a: assert property (conv_done && auto_index_enable |=>
        temperature_index_pointer inside {[8'h80:8'hAF]}) else $error("pointer out of range");
    host_ptr_a: assert property (idx_wr && !auto_index_enable && !conv_done |=>
        temperature_index_pointer == $past(idx_wdata)) else $error("pointer write lost");
    auto_block_a: assert property (idx_wr && auto_index_enable && !conv_done |=>
        $stable(temperature_index_pointer)) else $error("pointer written in auto");
    code_hold_a: assert property (!code_wr && !$past(conv_done) |=>
        $stable(output_channel_0)) else $error("code moved without cause");
    code_write_a: assert property (code_wr && code_sel == 2'h0 && !table_mode[0] |=>
        output_channel_0 == $past(code_wdata)) else $error("code write lost");
    bad_page_a: assert property (tbl_rd && !(tbl_page inside {[8'h04:8'h07]}) |=>
        tbl_rdata == 8'h00) else $error("bad page read not zero");
endmodule
bind tdsl_top tdsl_props chk (.clk_sys, .rst, .temp_value, .conv_done, .auto_index_enable,
    .table_mode, .idx_wr, .idx_wdata, .code_wr, .code_sel, .code_wdata, .tbl_rd, .tbl_page,
    .tbl_rdata, .temperature_index_pointer, .output_channel_0);

// ### testbench/temp_indexed_dac_setpoint_lut_tb.sv
// self-checking bench of the set point block
// assumes design files and host model compile first
`timescale 1ns/1ps
module temp_indexed_dac_setpoint_lut_tb;
    logic clk_sys = 1'b0, rst = 1'b1, conv_done = 1'b0, auto_index_enable = 1'b1;
    logic idx_wr = 1'b0, code_wr = 1'b0, tbl_wr, tbl_rd;
    logic [15:0] temp_value = 16'h0000;
    logic [3:0] table_mode = 4'hF;
    logic [1:0] code_sel = 2'h0;
    logic [7:0] idx_wdata = 8'h00, tbl_page, tbl_addr, tbl_wdata, tbl_rdata, ptr, rd, eptr = 8'h80;
    logic [9:0] codes [4];
    logic [9:0] code_wdata = 10'h000;
    logic [9:0] ecode [4] = '{4{10'h000}};
    int fails = 0, compares = 0, cyc = 0, prev_t = 0;
    int temps [18] = '{-50, -37, -36, -12, -9, -8, 8, 23, 52, 56, 57, 71, 88, 101, 102, 120, 55, 30};
    tdsl_top dut (.clk_sys, .rst, .temp_value, .conv_done, .auto_index_enable, .table_mode,
        .idx_wr, .idx_wdata, .tbl_wr, .tbl_rd, .tbl_page, .tbl_addr, .tbl_wdata, .code_wr,
        .code_sel, .code_wdata, .tbl_rdata, .temperature_index_pointer(ptr),
        .output_channel_0(codes[0]), .output_channel_1(codes[1]),
        .output_channel_2(codes[2]), .output_channel_3(codes[3]));
    tdsl_host host (.clk_sys, .tbl_rdata, .tbl_wr, .tbl_rd, .tbl_page, .tbl_addr, .tbl_wdata);
    always #10 clk_sys = ~clk_sys;
    // hang guard, the run needs well under 2000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [7:0] idx_of(input int t);
        if (t < -40) return 8'h80;
        if (t < 56) return 8'(128 + (t + 40) / 4);
        if (t >= 102) return 8'hAF;
        return 8'(128 + (t - 8) / 2);
    endfunction
    // coarse entry follows the fine entry, sum saturates at full scale
    function automatic logic [9:0] code_of(input int c, input int f);
        int k, s;
        k = f < 8 ? 0 : f < 24 ? (f - 8) / 4 + 1 : (f - 24) / 8 + 5;
        s = c * 64 + f + 4 * (c * 80 + (k > 7 ? 7 : k));
        return s > 1023 ? 10'h3FF : 10'(s);
    endfunction
    task automatic chk_codes;
        for (int c = 0; c < 4; c++) begin
            if (table_mode[c]) ecode[c] = code_of(c, int'(eptr) - 128);
            check(codes[c], ecode[c]);
        end
    endtask
    task automatic conv(input int t);
        @(negedge clk_sys);
        temp_value <= {8'(t), 8'h00};
        conv_done <= 1'b1;
        if (auto_index_enable) eptr = idx_of(t < prev_t ? t + 1 : t);
        prev_t = t;
        @(negedge clk_sys);
        conv_done <= 1'b0;
        check(10'(ptr), 10'(eptr));
        @(negedge clk_sys);
        chk_codes();
    endtask
    task automatic t_reset;
        check(10'(ptr), 10'h080);
        check(10'(tbl_rdata), 10'h000);
        for (int c = 0; c < 4; c++) check(codes[c], 10'h000);
    endtask
    task automatic t_tables;
        host.program_all();
        host.get(8'h06, 8'h85, rd);
        check(10'(rd), 10'd133);
        host.get(8'h07, 8'hFB, rd);
        check(10'(rd), 10'd243);
        host.put(8'h08, 8'h80, 8'h5A);
        host.get(8'h08, 8'h80, rd);
        check(10'(rd), 10'h000);
        host.get(8'h04, 8'hB0, rd);
        check(10'(rd), 10'h000);
    endtask
    task automatic t_sweep;
        foreach (temps[i]) conv(temps[i]);
    endtask
    task automatic code_write(input logic [1:0] s, input logic [9:0] v);
        @(negedge clk_sys);
        {code_wr, code_sel, code_wdata} <= {1'b1, s, v};
        @(negedge clk_sys);
        code_wr <= 1'b0;
        if (!table_mode[s]) ecode[s] = v;
        chk_codes();
    endtask
    // host pointer, refused writes, channels outside table mode
    task automatic t_manual;
        @(negedge clk_sys);
        {auto_index_enable, idx_wr, idx_wdata} <= {2'b01, 8'hA0};
        @(negedge clk_sys);
        idx_wr <= 1'b0;
        eptr = 8'hA0;
        check(10'(ptr), 10'h0A0);
        conv(20);
        table_mode <= 4'h2;
        code_write(2'h1, 10'h155);
        code_write(2'h0, 10'h2AA);
        conv(-20);
        @(negedge clk_sys);
        {auto_index_enable, idx_wr, idx_wdata} <= {2'b11, 8'h90};
        @(negedge clk_sys);
        idx_wr <= 1'b0;
        check(10'(ptr), 10'(eptr));
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_tables();
        t_sweep();
        t_manual();
        test_done();
    end
endmodule
